// >>> logic/rqsb_pkg.sv
// Package of offsets, field positions, commands and reset values for the queue 2 status bank
package rqsb_pkg;
   // Register offsets on the host register port
   localparam logic [7:0] STATUS_UPPER_ADDR = 8'h61;
   localparam logic [7:0] STATUS_LOWER_ADDR = 8'h62;
   localparam logic [7:0] MASK_UPPER_ADDR   = 8'h63;
   localparam logic [7:0] MASK_LOWER_ADDR   = 8'h64;
   // Commands that release the queue lock
   localparam logic [7:0] CMD_CLR_RX_LOCK   = 8'h20;
   localparam logic [7:0] CMD_CLR_ALL_LOCK  = 8'h3f;
   // Upper half field positions
   localparam int UP_COMPLETE  = 15;
   localparam int UP_EMPTY     = 14;
   localparam int UP_ABORT     = 13;
   localparam int UP_FULL      = 12;
   localparam int UP_OVERFLOW  = 11;
   localparam int UP_PERR_Q2   = 3;
   localparam int UP_PERR_Q1   = 2;
   localparam int UP_UNLOCKED  = 1;
   // Lower half field positions
   localparam int LO_SRC_EXACT = 7;
   localparam int LO_SRC_MATCH = 6;
   localparam int LO_DST_EXACT = 5;
   localparam int LO_DST_MATCH = 4;
   localparam int LO_LINE_DONE = 1;
   localparam int LO_FILT_DONE = 0;
   // Bits that exist in each half; the rest read as zero
   localparam logic [15:0] UPPER_IMPL = 16'hf80e;
   localparam logic [15:0] LOWER_IMPL = 16'h00f3;
   // Reset values
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [15:0] MASK_RESET   = 16'h0000;
   localparam logic [15:0] DATA_ZERO    = 16'h0000;
   // Register access takes two clock cycles from strobe to ready
   localparam int ACCESS_CYCLES = 2;
   // Queue pointer width
   localparam int PTR_W = 16;
endpackage

// >>> logic/rqsb_queue_lock.sv
// Queue 2 lock tracking: full lock, command release and auto-unlock
`timescale 1ns/1ps
`default_nettype none
module rqsb_queue_lock
(
   // Clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst_b,
   // Pointer events
   input  wire logic                     wr_ptr_inc,
   input  wire logic                     rd_ptr_inc,
   input  wire logic [rqsb_pkg::PTR_W-1:0] q2_read_pointer,
   input  wire logic [rqsb_pkg::PTR_W-1:0] q2_write_pointer,
   input  wire logic                     unlock_threshold_crossed,
   input  wire logic                     auto_unlock_en,
   // Command release
   input  wire logic                     cmd_release,
   // Results
   output logic                          locked,
   output logic                          empty,
   output logic                          auto_unlock_pulse
);
   logic locked_reg;
   logic locked_next;
   logic empty_reg;
   logic empty_next;
   logic ptr_equal;
   logic auto_rel;

   assign ptr_equal = (q2_read_pointer == q2_write_pointer);
   // Auto release once host reads drain past the threshold
   assign auto_rel  = locked_reg & auto_unlock_en & unlock_threshold_crossed;
   // Lock on full, released by command or auto-unlock
   assign locked_next = (wr_ptr_inc & ptr_equal) |
                        (locked_reg & ~cmd_release & ~auto_rel);
   // Empty follows the pointers: set on drain, reset while frames remain
   assign empty_next = (rd_ptr_inc & ptr_equal) ? 1'b1 :
                       (wr_ptr_inc | ~ptr_equal) ? 1'b0 : empty_reg;
   assign locked = locked_reg;
   assign empty  = empty_reg;
   assign auto_unlock_pulse = auto_rel;

   // Lock and empty state
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         locked_reg <= 1'b0;
         empty_reg  <= 1'b1;
      end
      else
      begin
         locked_reg <= locked_next;
         empty_reg  <= empty_next;
      end
   end
endmodule // rqsb_queue_lock
`default_nettype wire

// >>> logic/rqsb_status_bank.sv
// Queue 2 event status and interrupt mask bank on the host register port
//
// Contract
// - 32-bit read-only status word: upper half at 61h, lower at 62h.
// - 32-bit read/write mask, one enable per status bit.
// - Every status bit can raise the interrupt when its mask allows.
// - Reading a half clears its flags except queue empty and full.
// - Empty flag follows its condition continuously; full holds until a release command or auto-unlock.
// - Bit 15 sets on frame finish, aborted frames too, flushed not.
// - Completion flag works alike in tag and modified tag mode.
// - Bit 14 sets when read equals write after read increment.
// - Reading an empty queue raises an interrupt through the empty flag.
// - Bit 13 sets on aborted frames, threshold aborts included.
// - Bit 12 sets when pointers meet after write increment; queue locks.
// - Commands 20h, 3fh or auto-unlock clear full flag and lock.
// - Bit 11 sets when the receive FIFO overflows and data is lost.
// - While overflow is set, frame-copied is not set on repeated frames.
// - Upper bit 3 sets on parity error in queue 2 data.
// - Upper bit 2 sets on parity error in queue 1 data.
// - Upper bit 1 sets when auto-unlock releases the queue 2 lock.
// - Host reads past unlock threshold clear the lock and reopen the queue.
// - Reserved bits read as zero.
// - Lower bit 1 on line self-test done, bit 0 on filter self-test done.
// - Lower bits 7 to 4 report source and destination filter match results.
`timescale 1ns/1ps
`default_nettype none
module rqsb_status_bank
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // Host register port
   input  wire logic        host_sel_b,
   input  wire logic        host_read,
   input  wire logic [7:0]  host_register_address,
   input  wire logic [15:0] host_wdata,
   output logic [15:0]      host_rdata,
   output logic             host_rdata_oe,
   output logic             host_ready,
   // Host command strobe
   input  wire logic        cmd_valid,
   input  wire logic [7:0]  cmd_code,
   // Receive queue 2 events
   input  wire logic        rx_frame_done,
   input  wire logic        rx_frame_aborted,
   input  wire logic        rx_frame_flushed,
   input  wire logic        tag_mode,
   input  wire logic        mod_tag_mode,
   input  wire logic        rx_fifo_overflow,
   input  wire logic        parity_err_q2,
   input  wire logic        parity_err_q1,
   input  wire logic        q2_read_attempt,
   // Queue 2 pointers
   input  wire logic        wr_ptr_inc,
   input  wire logic        rd_ptr_inc,
   input  wire logic [15:0] q2_read_pointer,
   input  wire logic [15:0] q2_write_pointer,
   input  wire logic        unlock_threshold_crossed,
   input  wire logic        auto_unlock_en,
   // Filter and self-test events
   input  wire logic        int_filter_src_exact,
   input  wire logic        int_filter_src_match,
   input  wire logic        int_filter_dst_exact,
   input  wire logic        int_filter_dst_match,
   input  wire logic        line_ctrl_selftest_done,
   input  wire logic        filter_selftest_done,
   // Frame status request
   input  wire logic        repeat_frame_copy_req,
   output logic             frame_copied_ind,
   // Queue and interrupt outputs
   output logic             q2_locked,
   output logic             irq
);
   typedef enum logic [2:0] {
      RQSB_IDLE = 3'b001,
      RQSB_WAIT = 3'b010,
      RQSB_DONE = 3'b100
   } rqsb_state_t;

   rqsb_state_t state_reg;
   rqsb_state_t state_next;
   logic [15:0] mask_up_reg;
   logic [15:0] mask_lo_reg;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic        rdata_oe_reg;
   logic        ready_reg;
   logic        copied_reg;
   logic [15:0] up_set;
   logic [15:0] lo_set;
   logic [15:0] up_flags;
   logic [15:0] lo_flags;
   logic [15:0] up_word;
   logic [15:0] lo_word;
   logic        access_end;
   logic        rd_up;
   logic        rd_lo;
   logic        wr_mask_up;
   logic        wr_mask_lo;
   logic        cmd_release;
   logic        lock_flag;
   logic        empty_flag;
   logic        auto_pulse;
   logic        frame_end;

   // Address match used by read and write decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // Access sequencing: select taken, one wait cycle, then flags and data captured
   assign access_end = (state_reg == RQSB_WAIT);
   assign rd_up      = access_end & host_read & hit(host_register_address,
                                                    rqsb_pkg::STATUS_UPPER_ADDR);
   assign rd_lo      = access_end & host_read & hit(host_register_address,
                                                    rqsb_pkg::STATUS_LOWER_ADDR);
   assign wr_mask_up = access_end & ~host_read & hit(host_register_address,
                                                     rqsb_pkg::MASK_UPPER_ADDR);
   assign wr_mask_lo = access_end & ~host_read & hit(host_register_address,
                                                     rqsb_pkg::MASK_LOWER_ADDR);
   assign cmd_release = cmd_valid & ((cmd_code == rqsb_pkg::CMD_CLR_RX_LOCK) |
                                     (cmd_code == rqsb_pkg::CMD_CLR_ALL_LOCK));

   // State transitions
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         RQSB_IDLE: if (!host_sel_b) state_next = RQSB_WAIT;
         RQSB_WAIT: state_next = RQSB_DONE;
         RQSB_DONE: if (host_sel_b) state_next = RQSB_IDLE;
         default:   state_next = RQSB_IDLE;
      endcase
   end

   // Queue lock and empty tracking
   rqsb_queue_lock u_lock
   (
      .core_clk                 (core_clk),
      .rst_b                    (rst_b),
      .wr_ptr_inc               (wr_ptr_inc),
      .rd_ptr_inc               (rd_ptr_inc),
      .q2_read_pointer          (q2_read_pointer),
      .q2_write_pointer         (q2_write_pointer),
      .unlock_threshold_crossed (unlock_threshold_crossed),
      .auto_unlock_en           (auto_unlock_en),
      .cmd_release              (cmd_release),
      .locked                   (lock_flag),
      .empty                    (empty_flag),
      .auto_unlock_pulse        (auto_pulse)
   );

   // Completion counts finished and aborted frames in either tag mode
   assign frame_end = (rx_frame_done | rx_frame_aborted) & ~rx_frame_flushed &
                      (tag_mode | mod_tag_mode);

   // Event sources of each sticky bit
   assign up_set = {frame_end,
                    1'b0,
                    rx_frame_aborted,
                    1'b0,
                    rx_fifo_overflow,
                    7'b000_0000,
                    parity_err_q2,
                    parity_err_q1,
                    auto_pulse,
                    1'b0};
   assign lo_set = {8'h00,
                    int_filter_src_exact,
                    int_filter_src_match,
                    int_filter_dst_exact,
                    int_filter_dst_match,
                    2'b00,
                    line_ctrl_selftest_done,
                    filter_selftest_done};

   // Sticky flags cleared by the read of their half
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1)
      begin : g_flags
         if (rqsb_pkg::UPPER_IMPL[g] && g != rqsb_pkg::UP_EMPTY &&
             g != rqsb_pkg::UP_FULL)
         begin : g_up
            rqsb_sticky_flag u_up
            (
               .core_clk  (core_clk),
               .rst_b     (rst_b),
               .set_pulse (up_set[g]),
               .clr_pulse (rd_up),
               .flag      (up_flags[g])
            );
         end
         else
         begin : g_up_z
            assign up_flags[g] = 1'b0;
         end
         if (rqsb_pkg::LOWER_IMPL[g])
         begin : g_lo
            rqsb_sticky_flag u_lo
            (
               .core_clk  (core_clk),
               .rst_b     (rst_b),
               .set_pulse (lo_set[g]),
               .clr_pulse (rd_lo),
               .flag      (lo_flags[g])
            );
         end
         else
         begin : g_lo_z
            assign lo_flags[g] = 1'b0;
         end
      end
   endgenerate

   // Assembled words; empty and full are live levels, reserved read zero
   assign up_word = (up_flags & rqsb_pkg::UPPER_IMPL) |
                    ({15'h0000, empty_flag} << rqsb_pkg::UP_EMPTY) |
                    ({15'h0000, lock_flag} << rqsb_pkg::UP_FULL);
   assign lo_word = lo_flags & rqsb_pkg::LOWER_IMPL;

   // Read data selection
   assign rdata_next = rd_up ? up_word :
                       rd_lo ? lo_word :
                       hit(host_register_address, rqsb_pkg::MASK_UPPER_ADDR) &
                       access_end ? mask_up_reg :
                       hit(host_register_address, rqsb_pkg::MASK_LOWER_ADDR) &
                       access_end ? mask_lo_reg : rdata_reg;

   // Interrupt: any enabled bit; empty only interrupts on a read attempt
   assign irq = |((up_word & ~({15'h0000, empty_flag & ~q2_read_attempt}
                               << rqsb_pkg::UP_EMPTY)) & mask_up_reg) |
                |(lo_word & mask_lo_reg);

   assign host_ready       = ready_reg;
   assign host_rdata       = rdata_reg;
   assign host_rdata_oe    = rdata_oe_reg;
   assign q2_locked        = lock_flag;
   assign frame_copied_ind = copied_reg;

   // Access state; ready is registered so that it stands with the read data
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= RQSB_IDLE;
         ready_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         ready_reg <= access_end;
      end
   end

   // Mask registers
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mask_up_reg <= rqsb_pkg::MASK_RESET;
         mask_lo_reg <= rqsb_pkg::MASK_RESET;
      end
      else
      begin
         if (wr_mask_up) mask_up_reg <= host_wdata;
         if (wr_mask_lo) mask_lo_reg <= host_wdata;
      end
   end

   // Read data and drive enable held until select drops
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rdata_reg    <= rqsb_pkg::DATA_ZERO;
         rdata_oe_reg <= 1'b0;
      end
      else
      begin
         rdata_reg    <= rdata_next;
         rdata_oe_reg <= host_read & ~host_sel_b & (state_reg != RQSB_IDLE);
      end
   end

   // Frame-copied indicator suppressed while overflow stands
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         copied_reg <= 1'b0;
      else
         copied_reg <= repeat_frame_copy_req &
                       ~up_flags[rqsb_pkg::UP_OVERFLOW];
   end

   // Checks
   ready_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      host_ready |=> !host_ready)
      else $error("ready longer than one cycle");
   ready_delay_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (state_reg == RQSB_IDLE && !host_sel_b) |-> ##2 host_ready)
      else $error("ready not on third edge");
   oe_read_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (host_ready && host_read) |-> host_rdata_oe)
      else $error("read data not driven at ready");
   read_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (rd_up && !up_set[rqsb_pkg::UP_COMPLETE]) |=> !up_flags[rqsb_pkg::UP_COMPLETE])
      else $error("completion not cleared by read");
   empty_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (rd_up && empty_flag && !wr_ptr_inc && q2_read_pointer == q2_write_pointer)
      |=> up_word[rqsb_pkg::UP_EMPTY])
      else $error("empty cleared by read");
   empty_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (rd_ptr_inc && q2_read_pointer == q2_write_pointer) |=> up_word[rqsb_pkg::UP_EMPTY])
      else $error("empty not set on drain");
   empty_irq_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (empty_flag && q2_read_attempt && mask_up_reg[rqsb_pkg::UP_EMPTY]) |-> irq)
      else $error("no irq on read of empty queue");
   complete_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (rx_frame_done && !rx_frame_flushed && (tag_mode || mod_tag_mode))
      |=> up_flags[rqsb_pkg::UP_COMPLETE])
      else $error("completion not set");
   parity_set_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      parity_err_q1 |=> up_flags[rqsb_pkg::UP_PERR_Q1])
      else $error("queue 1 parity event lost");
   set_wins_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      rx_fifo_overflow |=> up_flags[rqsb_pkg::UP_OVERFLOW])
      else $error("overflow event lost");
   full_lock_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (wr_ptr_inc && q2_read_pointer == q2_write_pointer) |=> up_word[rqsb_pkg::UP_FULL])
      else $error("full not set");
   cmd_unlock_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (cmd_release && !wr_ptr_inc) |=> !q2_locked)
      else $error("lock command ignored");
   auto_flag_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      auto_pulse |=> (!q2_locked && up_flags[rqsb_pkg::UP_UNLOCKED]))
      else $error("auto-unlock not reported");
   reserved_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (up_word[10:4] == 7'h00) && (lo_word[15:8] == 8'h00))
      else $error("reserved bit set");
   irq_mask_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (mask_up_reg == 16'h0000 && mask_lo_reg == 16'h0000) |-> !irq)
      else $error("irq with all masked");
   copied_block_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      up_flags[rqsb_pkg::UP_OVERFLOW] |=> !frame_copied_ind)
      else $error("copied set during overflow");

   read_cov_c:   cover property (@(posedge core_clk) rd_up ##[1:20] rd_lo);
   lock_cov_c:   cover property (@(posedge core_clk) q2_locked ##[1:20] auto_pulse);
   irq_cov_c:    cover property (@(posedge core_clk) irq ##1 rd_up);
   copy_cov_c:   cover property (@(posedge core_clk) frame_copied_ind ##1 !frame_copied_ind);
endmodule // rqsb_status_bank
`default_nettype wire

// >>> logic/rqsb_sticky_flag.sv
// One sticky event flag with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
module rqsb_sticky_flag
(
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_b,
   // Set and clear
   input  wire logic set_pulse,
   input  wire logic clr_pulse,
   // Flag out
   output logic      flag
);
   logic flag_reg;
   logic flag_next;

   // Event in the clearing cycle is kept
   assign flag_next = set_pulse | (flag_reg & ~clr_pulse);
   assign flag      = flag_reg;

   // Flag storage
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         flag_reg <= 1'b0;
      else
         flag_reg <= flag_next;
   end
endmodule // rqsb_sticky_flag
`default_nettype wire

// >>> sim/rqsb_host_model.sv
// Node processor model that runs accesses on the host register port
`timescale 1ns/1ps
`default_nettype none
module rqsb_host_model
(
   // Clock
   input  wire logic        core_clk,
   // Host register port
   output logic             host_sel_b,
   output logic             host_read,
   output logic [7:0]       host_register_address,
   output logic [15:0]      host_wdata,
   input  wire logic [15:0] host_rdata,
   input  wire logic        host_ready,
   // Ready never came
   output logic             hang
);
   // Idle bus at time zero
   initial
   begin
      host_sel_b = 1'b1;
      host_read = 1'b1;
      host_register_address = 8'h00;
      host_wdata = 16'h0000;
      hang = 1'b0;
   end

   // Hold the request until ready is sampled, take the data there, then release and scramble
   task automatic xfer(input logic rd, input logic [7:0] a, input logic [15:0] wd,
                       output logic [15:0] q);
      int n;
      n = 0;
      @(posedge core_clk);
      host_sel_b <= 1'b0;
      host_read <= rd;
      host_register_address <= a;
      host_wdata <= wd;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (host_ready !== 1'b1 && n < 8);
      if (host_ready !== 1'b1)
         hang <= 1'b1;
      q = host_rdata;
      host_sel_b <= 1'b1;
      host_register_address <= ~a;
      host_wdata <= ~wd;
      @(posedge core_clk);
   endtask
endmodule // rqsb_host_model
`default_nettype wire

// >>> sim/rqsb_status_bank_tb.sv
// Self-checking bench for the queue 2 status and mask bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      total_checks++; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module rqsb_status_bank_tb;
   logic        core_clk, rst_b, host_sel_b, host_read, host_rdata_oe, host_ready;
   logic [7:0]  host_register_address, cmd_code;
   logic [15:0] host_wdata, host_rdata, q2_read_pointer, q2_write_pointer, q;
   logic [14:0] ev;
   logic        tag_mode, mod_tag_mode, q2_read_attempt, unlock_threshold_crossed;
   logic        auto_unlock_en, repeat_frame_copy_req, frame_copied_ind, q2_locked;
   logic        irq, hang;
   int          n_mismatch, total_checks, cyc;
   logic [7:0]  codes [3] = '{8'h21, rqsb_pkg::CMD_CLR_RX_LOCK, rqsb_pkg::CMD_CLR_ALL_LOCK};

   // Design and host model
   rqsb_status_bank uut (.core_clk, .rst_b, .host_sel_b, .host_read,
      .host_register_address, .host_wdata, .host_rdata, .host_rdata_oe, .host_ready,
      .cmd_valid(ev[14]), .cmd_code, .rx_frame_done(ev[0]), .rx_frame_aborted(ev[1]),
      .rx_frame_flushed(ev[2]), .tag_mode, .mod_tag_mode, .rx_fifo_overflow(ev[3]),
      .parity_err_q2(ev[4]), .parity_err_q1(ev[5]), .q2_read_attempt,
      .wr_ptr_inc(ev[12]), .rd_ptr_inc(ev[13]), .q2_read_pointer, .q2_write_pointer,
      .unlock_threshold_crossed, .auto_unlock_en, .int_filter_src_exact(ev[6]),
      .int_filter_src_match(ev[7]), .int_filter_dst_exact(ev[8]),
      .int_filter_dst_match(ev[9]), .line_ctrl_selftest_done(ev[10]),
      .filter_selftest_done(ev[11]), .repeat_frame_copy_req, .frame_copied_ind,
      .q2_locked, .irq);
   rqsb_host_model host (.core_clk, .host_sel_b, .host_read, .host_register_address,
      .host_wdata, .host_rdata, .host_ready, .hang);

   // Clock
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Cut a hang short
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000 || hang)
      begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      host.xfer(1'b1, a, 16'h0000, d);
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [15:0] x;
      host.xfer(1'b0, a, d, x);
   endtask

   // One-cycle event pulses, settled at the following falling edge
   task automatic pulse(input logic [14:0] m);
      @(posedge core_clk);
      ev <= m;
      @(posedge core_clk);
      ev <= 15'h0000;
      @(negedge core_clk);
   endtask

   task automatic t_reset();
      `CHK({host_rdata_oe, irq, q2_locked}, 3'b000)
      rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
      `CHK(q, 16'h4000)
      wr(rqsb_pkg::STATUS_UPPER_ADDR, 16'hffff);
      rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
      `CHK(q, 16'h4000)
      rd(rqsb_pkg::STATUS_LOWER_ADDR, q);
      `CHK(q, 16'h0000)
      rd(rqsb_pkg::MASK_UPPER_ADDR, q);
      `CHK(q, rqsb_pkg::MASK_RESET)
      rd(rqsb_pkg::MASK_LOWER_ADDR, q);
      `CHK(q, rqsb_pkg::MASK_RESET)
      $display("reset test done");
   endtask

   task automatic t_mask();
      wr(rqsb_pkg::MASK_UPPER_ADDR, rqsb_pkg::UPPER_IMPL);
      wr(rqsb_pkg::MASK_LOWER_ADDR, rqsb_pkg::LOWER_IMPL);
      rd(rqsb_pkg::MASK_UPPER_ADDR, q);
      `CHK(q, rqsb_pkg::UPPER_IMPL)
      rd(rqsb_pkg::MASK_LOWER_ADDR, q);
      `CHK(q, rqsb_pkg::LOWER_IMPL)
      rd(8'h70, q);
      `CHK(q, rqsb_pkg::LOWER_IMPL)
      wr(rqsb_pkg::MASK_UPPER_ADDR, 16'h0000);
      wr(rqsb_pkg::MASK_LOWER_ADDR, 16'h0000);
      $display("mask test done");
   endtask

   task automatic t_events();
      @(posedge core_clk);
      tag_mode <= 1'b1;
      pulse(15'h0004);
      rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
      `CHK(q, 16'h4000)
      pulse(15'h0039);
      `CHK(irq, 1'b0)
      rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
      `CHK(q, 16'hc80c)
      rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
      `CHK(q, 16'h4000)
      pulse(15'h0002);
      rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
      `CHK(q, 16'he000)
      tag_mode <= 1'b0;
      mod_tag_mode <= 1'b1;
      pulse(15'h0001);
      rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
      `CHK(q, 16'hc000)
      mod_tag_mode <= 1'b0;
      pulse(15'h0fc0);
      rd(rqsb_pkg::STATUS_LOWER_ADDR, q);
      `CHK(q, 16'h00f3)
      rd(rqsb_pkg::STATUS_LOWER_ADDR, q);
      `CHK(q, 16'h0000)
      $display("event test done");
   endtask

   task automatic t_irq();
      wr(rqsb_pkg::MASK_UPPER_ADDR, 16'h0800);
      pulse(15'h0010);
      `CHK(irq, 1'b0)
      pulse(15'h0008);
      `CHK(irq, 1'b1)
      rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
      `CHK({q, irq}, {16'h4808, 1'b0})
      wr(rqsb_pkg::MASK_UPPER_ADDR, 16'h4000);
      `CHK(irq, 1'b0)
      q2_read_attempt <= 1'b1;
      @(negedge core_clk);
      `CHK(irq, 1'b1)
      @(posedge core_clk);
      q2_read_attempt <= 1'b0;
      wr(rqsb_pkg::MASK_UPPER_ADDR, 16'h0000);
      wr(rqsb_pkg::MASK_LOWER_ADDR, 16'h0001);
      pulse(15'h0800);
      `CHK(irq, 1'b1)
      rd(rqsb_pkg::STATUS_LOWER_ADDR, q);
      `CHK({q, irq}, {16'h0001, 1'b0})
      wr(rqsb_pkg::MASK_LOWER_ADDR, 16'h0000);
      $display("interrupt test done");
   endtask

   task automatic t_lock();
      @(posedge core_clk);
      q2_read_pointer <= 16'h0005;
      q2_write_pointer <= 16'h0004;
      pulse(15'h1000);
      `CHK(q2_locked, 1'b0)
      @(posedge core_clk);
      q2_write_pointer <= 16'h0005;
      pulse(15'h1000);
      `CHK(q2_locked, 1'b1)
      repeat (2)
      begin
         rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
         `CHK(q, 16'h1000)
      end
      for (int i = 0; i < 3; i++)
      begin
         @(posedge core_clk);
         cmd_code <= codes[i];
         pulse(15'h4000);
         `CHK(q2_locked, i == 0)
         if (i > 0)
         begin
            rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
            `CHK(q, 16'h0000)
            pulse(15'h1000);
            `CHK(q2_locked, 1'b1)
         end
      end
      @(posedge core_clk);
      auto_unlock_en <= 1'b1;
      unlock_threshold_crossed <= 1'b1;
      repeat (4) @(negedge core_clk);
      `CHK(q2_locked, 1'b0)
      rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
      `CHK(q, 16'h0002)
      rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
      `CHK(q, 16'h0000)
      unlock_threshold_crossed <= 1'b0;
      pulse(15'h2000);
      rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
      `CHK(q, 16'h4000)
      $display("lock test done");
   endtask

   task automatic t_copy();
      repeat_frame_copy_req <= 1'b1;
      pulse(15'h0000);
      `CHK(frame_copied_ind, 1'b1)
      pulse(15'h0008);
      @(negedge core_clk);
      `CHK(frame_copied_ind, 1'b0)
      rd(rqsb_pkg::STATUS_UPPER_ADDR, q);
      `CHK(q, 16'h4800)
      @(negedge core_clk);
      `CHK(frame_copied_ind, 1'b1)
      @(posedge core_clk);
      repeat_frame_copy_req <= 1'b0;
      $display("copy test done");
   endtask

   // Main sequence
   initial
   begin
      {rst_b, ev, cmd_code, tag_mode, mod_tag_mode, q2_read_attempt} = '0;
      {q2_read_pointer, q2_write_pointer, unlock_threshold_crossed} = '0;
      {auto_unlock_en, repeat_frame_copy_req, n_mismatch, total_checks, cyc} = '0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      @(negedge core_clk);
      t_reset();
      t_mask();
      t_events();
      t_irq();
      t_lock();
      t_copy();
      test_done();
   end
endmodule // rqsb_status_bank_tb
`default_nettype wire
